/* File: hw/uhpet_pkg.sv */
package uhpet_pkg;

	// ----------------------------------------------------------------
	// Clock and counter width
	// ----------------------------------------------------------------
	localparam real CLK_NS = 4.0;
	localparam int  CW     = 27;

	// ----------------------------------------------------------------
	// Times in their own units
	// ----------------------------------------------------------------
	localparam real T_DRST_MS  = 10.0;
	localparam real T_DRSM_MS  = 20.0;
	localparam real T_URSM_MS  = 1.0;
	localparam real T_WRSM_MS  = 5.0;
	localparam real T_REV_MS   = 3.0;
	localparam real T_UCH_MS   = 1.0;
	localparam real T_REQ_MS   = 50.0;
	localparam real T_DATA_MS  = 500.0;
	localparam real T_CHBIT_US = 40.0;
	localparam real T_CHEND_US = 100.0;
	localparam real T_FILT_US  = 2.5;
	localparam real T_DIS_US   = 2.0;
	localparam real T_LK_US    = 2.5;
	localparam real T_DET_US   = 2.5;

	// Bit periods and bit-time figures.
	localparam real FS_BIT_NS = 1000.0 / 12.0;
	localparam real HS_BIT_NS = 1000.0 / 480.0;
	localparam real B_REP     = 23.0;
	localparam real B_HS_SAME = 88.0;
	localparam real B_HS_OPP  = 8.0;
	localparam real B_HS_RSP  = 192.0;
	localparam real B_FS_IPD  = 2.0;
	localparam real B_FS_RSP  = 6.5;

	// ----------------------------------------------------------------
	// Cycle counts: least times round up, longest times round down
	// ----------------------------------------------------------------
	localparam int unsigned C_DRST  = int'($ceil(T_DRST_MS*1.0e6/CLK_NS));
	localparam int unsigned C_DRSM  = int'($ceil(T_DRSM_MS*1.0e6/CLK_NS));
	localparam int unsigned C_URSM  = int'($ceil(T_URSM_MS*1.0e6/CLK_NS));
	localparam int unsigned C_WAKE  = int'($ceil(T_WRSM_MS*1.0e6/CLK_NS));
	localparam int unsigned C_REV   = int'($ceil(T_REV_MS*1.0e6/CLK_NS));
	localparam int unsigned C_UCH   = int'($ceil(T_UCH_MS*1.0e6/CLK_NS));
	localparam int unsigned C_REQ   = int'($floor(T_REQ_MS*1.0e6/CLK_NS));
	localparam int unsigned C_DATA  = int'($floor(T_DATA_MS*1.0e6/CLK_NS));
	localparam int unsigned C_CHBIT = int'($ceil(T_CHBIT_US*1.0e3/CLK_NS));
	localparam int unsigned C_CHEND = int'($ceil(T_CHEND_US*1.0e3/CLK_NS));
	localparam int unsigned C_FILT  = int'($ceil(T_FILT_US*1.0e3/CLK_NS));
	localparam int unsigned C_DIS   = int'($ceil(T_DIS_US*1.0e3/CLK_NS));
	localparam int unsigned C_LK    = int'($ceil(T_LK_US*1.0e3/CLK_NS));
	localparam int unsigned C_DET   = int'($ceil(T_DET_US*1.0e3/CLK_NS));
	localparam int unsigned C_REP   = int'($floor(B_REP*FS_BIT_NS/CLK_NS));
	localparam int unsigned C_HS_SAME = int'($ceil(B_HS_SAME*HS_BIT_NS/CLK_NS));
	localparam int unsigned C_HS_OPP  = int'($ceil(B_HS_OPP*HS_BIT_NS/CLK_NS));
	localparam int unsigned C_HS_RSP  = int'($floor(B_HS_RSP*HS_BIT_NS/CLK_NS));
	localparam int unsigned C_FS_IPD  = int'($ceil(B_FS_IPD*FS_BIT_NS/CLK_NS));
	localparam int unsigned C_FS_RSP  = int'($floor(B_FS_RSP*FS_BIT_NS/CLK_NS));

	// ----------------------------------------------------------------
	// Synchroniser lanes
	// ----------------------------------------------------------------
	localparam int SY_US_SE0 = 0;
	localparam int SY_US_K   = 1;
	localparam int SY_DS_SE0 = 2;
	localparam int SY_DS_K   = 3;

	// ----------------------------------------------------------------
	// Downstream chirp sequencer
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CH_IDLE = 3'b000,
		CH_WAIT = 3'b001,
		CH_DEVK = 3'b010,
		CH_HUBK = 3'b011,
		CH_HUBJ = 3'b100,
		CH_DONE = 3'b101
	} uhpet_chirp_type;

endpackage

/* File: hw/uhpet_timing.sv */
`timescale 1ns/1ps
`default_nettype none

module uhpet_timing
	import uhpet_pkg::*;
#(
	parameter int unsigned P_DRST  = C_DRST,
	parameter int unsigned P_DRSM  = C_DRSM,
	parameter int unsigned P_URSM  = C_URSM,
	parameter int unsigned P_WAKE  = C_WAKE,
	parameter int unsigned P_REV   = C_REV,
	parameter int unsigned P_UCH   = C_UCH,
	parameter int unsigned P_REQ   = C_REQ,
	parameter int unsigned P_DATA  = C_DATA,
	parameter int unsigned P_CHBIT = C_CHBIT,
	parameter int unsigned P_CHEND = C_CHEND
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic us_se0_pin,
	input  wire logic us_k_pin,
	input  wire logic ds_se0_pin,
	input  wire logic ds_k_pin,
	input  wire logic port_reset_req,
	input  wire logic resume_req,
	input  wire logic port_suspended,
	input  wire logic wake_req,
	input  wire logic bus_active,
	input  wire logic hs_enter,
	input  wire logic us_chirp_req,
	input  wire logic rep_se0_req,
	input  wire logic pkt_end,
	input  wire logic pkt_expect_resp,
	input  wire logic resp_start,
	input  wire logic req_start,
	input  wire logic req_has_data,
	input  wire logic data_sent,
	input  wire logic next_is_last,
	input  wire logic req_done,
	output logic      ds_reset_drv,
	output logic      ds_chirp_k_drv,
	output logic      ds_chirp_j_drv,
	output logic      ds_resume_drv,
	output logic      us_resume_drv,
	output logic      us_chirp_k_drv,
	output logic      ds_disconnect,
	output logic      us_long_k,
	output logic      us_reset_det,
	output logic      fs_revert,
	output logic      hs_mode,
	output logic      rep_se0_en,
	output logic      gap_same_ok,
	output logic      gap_opp_ok,
	output logic      resp_late,
	output logic      req_active,
	output logic      req_timeout,
	output logic      wake_refused
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0]      s1;
		logic [3:0]      s2;
		logic            kprev;
		uhpet_chirp_type ch;
		logic [CW-1:0]   dsr;
		logic [CW-1:0]   filt;
		logic [CW-1:0]   chb;
		logic [CW-1:0]   drs;
		logic [CW-1:0]   urs;
		logic [CW-1:0]   idle;
		logic [CW-1:0]   disc;
		logic [CW-1:0]   lk;
		logic [CW-1:0]   det;
		logic [CW-1:0]   rev;
		logic [CW-1:0]   uck;
		logic [CW-1:0]   rep;
		logic [CW-1:0]   gap;
		logic [CW-1:0]   req;
		logic            rpend;
		logic            hs;
		logic            ds_reset;
		logic            chk;
		logic            chj;
		logic            ds_res;
		logic            us_res;
		logic            uchk;
		logic            disc_p;
		logic            long_k;
		logic            usrst_p;
		logic            rev_p;
		logic            rep_en;
		logic            gap_same;
		logic            gap_opp;
		logic            rlate_p;
		logic            req_on;
		logic            rto_p;
		logic            wref_p;
	} uhpet_state_type;

	uhpet_state_type q;
	uhpet_state_type n;

	logic [CW-1:0] thr_same;
	logic [CW-1:0] thr_opp;
	logic [CW-1:0] rsp_lim;
	logic          chirp_fits;
	logic          rsm_det;
	logic          wake_ok;
	logic          rev_fire;

	// ----------------------------------------------------------------
	// Counter helpers
	// ----------------------------------------------------------------
	// Persistence counter: clears when the condition drops and stops
	// at the target, so a detection fires once per episode.
	function automatic logic [CW-1:0] f_up(
		input logic          c,
		input logic [CW-1:0] v,
		input logic [CW-1:0] t
	);
		if (!c) begin
			return '0;
		end
		return (v >= t) ? t : v + 1'b1;
	endfunction

	function automatic logic [CW-1:0] f_dn(input logic [CW-1:0] v);
		return (v == '0) ? v : v - 1'b1;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n = q;
		n.s1 = {ds_k_pin, ds_se0_pin, us_k_pin, us_se0_pin};
		n.s2 = q.s1;
		n.kprev = q.s2[SY_DS_K];

		// Bit-time limits follow the negotiated speed.
		thr_same = q.hs ? CW'(C_HS_SAME) : CW'(C_FS_IPD);
		thr_opp  = q.hs ? CW'(C_HS_OPP) : CW'(C_FS_IPD);
		rsp_lim  = q.hs ? CW'(C_HS_RSP) : CW'(C_FS_RSP);

		// A new chirp bit only starts if it ends before the guard time.
		chirp_fits = q.dsr > CW'(P_CHBIT + P_CHEND);

		// Downstream reset and chirp handshake.
		n.dsr = f_dn(q.dsr);
		n.chb = f_dn(q.chb);
		n.filt = f_up(q.s2[SY_DS_K] && q.ch == CH_WAIT, q.filt,
			CW'(C_FILT));
		unique case (q.ch)
			CH_IDLE: begin
				n.ch = CH_IDLE;
			end
			CH_WAIT: begin
				if (q.filt == CW'(C_FILT)) begin
					n.ch = CH_DEVK;
				end
			end
			CH_DEVK: begin
				if (!q.s2[SY_DS_K]) begin
					if (chirp_fits) begin
						n.ch = CH_HUBK;
						n.chb = CW'(P_CHBIT);
					end else begin
						n.ch = CH_DONE;
					end
				end
			end
			CH_HUBK, CH_HUBJ: begin
				if (q.chb == CW'(1)) begin
					if (chirp_fits) begin
						n.ch = (q.ch == CH_HUBK) ? CH_HUBJ : CH_HUBK;
						n.chb = CW'(P_CHBIT);
					end else begin
						n.ch = CH_DONE;
					end
				end
			end
			CH_DONE: begin
				n.ch = CH_DONE;
			end
			default: begin
				n.ch = CH_IDLE;
			end
		endcase
		if (port_reset_req && q.dsr == '0) begin
			n.dsr = CW'(P_DRST);
			n.ch = CH_WAIT;
		end
		if (n.dsr == '0) begin
			n.ch = CH_IDLE;
		end

		// Downstream resume from this hub as controller.
		n.drs = f_dn(q.drs);
		if (resume_req && q.drs == '0) begin
			n.drs = CW'(P_DRSM);
		end

		// Upstream resume: rebroadcast or remote wakeup.
		rsm_det = q.s2[SY_DS_K] && !q.kprev && port_suspended &&
			q.dsr == '0;
		n.idle = f_up(!bus_active && !q.s2[SY_US_SE0] && !q.s2[SY_US_K],
			q.idle, CW'(P_WAKE));
		// The request cycle itself must be idle too, so the fresh count is
		// used; a bus that turns busy in that cycle refuses the wakeup.
		wake_ok = n.idle == CW'(P_WAKE);
		n.urs = f_dn(q.urs);
		if (q.urs == '0 && rsm_det) begin
			n.urs = CW'(P_URSM);
		end else if (q.urs == '0 && wake_req && wake_ok) begin
			n.urs = CW'(P_URSM);
		end
		n.wref_p = wake_req && !(wake_ok && q.urs == '0);

		// Line-state detectors. Our own reset drive is an SE0 as well,
		// so disconnect sensing is held off while it runs.
		n.disc = f_up(q.s2[SY_DS_SE0] && q.dsr == '0, q.disc,
			CW'(C_DIS));
		n.disc_p = n.disc == CW'(C_DIS) && q.disc != CW'(C_DIS);
		n.lk = f_up(q.s2[SY_US_K], q.lk, CW'(C_LK));
		n.long_k = n.lk == CW'(C_LK);
		n.det = f_up(q.s2[SY_US_SE0] && !q.hs, q.det, CW'(C_DET));
		n.usrst_p = n.det == CW'(C_DET) && q.det != CW'(C_DET);

		// Speed reversion; it wins over a same-cycle entry request.
		n.rev = f_up(q.s2[SY_US_SE0] && q.hs, q.rev, CW'(P_REV));
		rev_fire = n.rev == CW'(P_REV) && q.rev != CW'(P_REV);
		n.rev_p = rev_fire;
		if (rev_fire) begin
			n.hs = 1'b0;
		end else if (hs_enter) begin
			n.hs = 1'b1;
		end

		// Upstream chirp K.
		n.uck = f_dn(q.uck);
		if (us_chirp_req && q.uck == '0) begin
			n.uck = CW'(P_UCH);
		end

		// SE0 repeater cut-off.
		n.rep = f_up(rep_se0_req, q.rep, CW'(C_REP));
		n.rep_en = rep_se0_req && q.rep != CW'(C_REP);

		// Packet gaps and response window.
		n.gap = pkt_end ? '0 : f_up(1'b1, q.gap, CW'(C_FS_RSP));
		n.gap_same = !pkt_end && n.gap >= thr_same;
		n.gap_opp = !pkt_end && n.gap >= thr_opp;
		n.rlate_p = 1'b0;
		if (pkt_end) begin
			n.rpend = pkt_expect_resp;
		end else if (resp_start) begin
			n.rpend = 1'b0;
		end else if (q.rpend && q.gap == rsp_lim) begin
			n.rpend = 1'b0;
			n.rlate_p = 1'b1;
		end

		// Standard request budget.
		n.req = f_dn(q.req);
		if (req_done) begin
			n.req = '0;
		end else if (req_start) begin
			n.req = req_has_data ? CW'(P_DATA) : CW'(P_REQ);
		end else if (data_sent && q.req != '0) begin
			n.req = next_is_last ? CW'(P_REQ) : CW'(P_DATA);
		end
		n.rto_p = q.req == CW'(1) && n.req == '0;

		// Registered levels for the outputs.
		n.ds_reset = n.dsr != '0;
		n.chk = n.ch == CH_HUBK;
		n.chj = n.ch == CH_HUBJ;
		n.ds_res = n.drs != '0;
		n.us_res = n.urs != '0;
		n.uchk = n.uck != '0;
		n.req_on = n.req != '0;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign ds_reset_drv   = q.ds_reset;
	assign ds_chirp_k_drv = q.chk;
	assign ds_chirp_j_drv = q.chj;
	assign ds_resume_drv  = q.ds_res;
	assign us_resume_drv  = q.us_res;
	assign us_chirp_k_drv = q.uchk;
	assign ds_disconnect  = q.disc_p;
	assign us_long_k      = q.long_k;
	assign us_reset_det   = q.usrst_p;
	assign fs_revert      = q.rev_p;
	assign hs_mode        = q.hs;
	assign rep_se0_en     = q.rep_en;
	assign gap_same_ok    = q.gap_same;
	assign gap_opp_ok     = q.gap_opp;
	assign resp_late      = q.rlate_p;
	assign req_active     = q.req_on;
	assign req_timeout    = q.rto_p;
	assign wake_refused   = q.wref_p;

endmodule

`default_nettype wire

/* File: sim/uhpet_far_end.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Downstream device seen by the hub port
// ----------------------------------------------------------------
module uhpet_far_end (
	input  wire logic        clk,
	input  wire logic        ds_reset_drv,
	input  wire logic [11:0] klen,
	input  wire logic        disc,
	input  wire logic        rsm,
	output logic             ds_k_pin,
	output logic             ds_se0_pin
);
	logic kq;

	initial kq = 1'b0;
	// A short klen gives a chirp that the hub must not accept.
	always @(posedge ds_reset_drv) begin
		repeat (20) @(posedge clk);
		#1 kq = 1'b1;
		repeat (klen) @(posedge clk);
		#1 kq = 1'b0;
	end
	assign ds_k_pin   = kq | rsm;
	assign ds_se0_pin = disc;
endmodule

`default_nettype wire

/* File: sim/uhpet_timing_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module uhpet_timing_properties
	import uhpet_pkg::*;
#(
	parameter int unsigned P_DRST  = C_DRST,
	parameter int unsigned P_DRSM  = C_DRSM,
	parameter int unsigned P_URSM  = C_URSM,
	parameter int unsigned P_UCH   = C_UCH,
	parameter int unsigned P_CHBIT = C_CHBIT,
	parameter int unsigned P_CHEND = C_CHEND
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ds_se0_pin,
	input wire logic port_reset_req,
	input wire logic wake_req,
	input wire logic bus_active,
	input wire logic ds_reset_drv,
	input wire logic ds_chirp_k_drv,
	input wire logic ds_chirp_j_drv,
	input wire logic ds_resume_drv,
	input wire logic us_resume_drv,
	input wire logic us_chirp_k_drv,
	input wire logic ds_disconnect,
	input wire logic fs_revert,
	input wire logic hs_mode,
	input wire logic wake_refused
);
	// ----------------------------------------------------------------
	// Run-length counters
	// ----------------------------------------------------------------
	// Counters match the design's width so full-length times fit too.
	logic [CW-1:0] c0, c1, c3, c4, c5, cd;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{c0, c1, c3, c4, c5, cd} <= '0;
		end else begin
			c0 <= ds_reset_drv ? c0 + CW'(1) : '0;
			c1 <= ds_chirp_k_drv ? c1 + CW'(1) : '0;
			c3 <= ds_resume_drv ? c3 + CW'(1) : '0;
			c4 <= us_resume_drv ? c4 + CW'(1) : '0;
			c5 <= us_chirp_k_drv ? c5 + CW'(1) : '0;
			cd <= ds_se0_pin ? cd + CW'(1) : '0;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_drst_start: assert property (port_reset_req && !ds_reset_drv |=> ds_reset_drv)
		else $error("port reset drive did not start");
	a_drst_len: assert property ($fell(ds_reset_drv) |-> c0 == P_DRST)
		else $error("port reset length wrong");
	a_drsm_len: assert property ($fell(ds_resume_drv) |-> c3 == P_DRSM)
		else $error("downstream resume length wrong");
	a_ursm_len: assert property ($fell(us_resume_drv) |-> c4 == P_URSM)
		else $error("upstream resume length wrong");
	a_uch_len: assert property ($fell(us_chirp_k_drv) |-> c5 == P_UCH)
		else $error("upstream chirp length wrong");
	a_chirp_bit: assert property ($fell(ds_chirp_k_drv) |-> c1 == P_CHBIT)
		else $error("hub chirp bit length wrong");
	a_chirp_end: assert property (ds_chirp_k_drv || ds_chirp_j_drv |-> c0 < P_DRST - P_CHEND)
		else $error("hub chirp too close to reset end");
	a_rev_mode: assert property (fs_revert |-> !hs_mode && $past(hs_mode))
		else $error("revert without leaving high speed");
	a_wake_busy: assert property (wake_req && bus_active |=> wake_refused && !$rose(us_resume_drv))
		else $error("wakeup on busy bus not refused");
	a_disc_win: assert property (ds_disconnect |-> cd >= C_DIS && cd <= 625)
		else $error("disconnect outside its window");

	cover property ($fell(ds_chirp_j_drv));
	cover property (fs_revert);
	cover property (ds_disconnect);
	cover property (wake_refused);
endmodule

bind uhpet_timing uhpet_timing_properties #(.P_DRST(P_DRST), .P_DRSM(P_DRSM),
	.P_URSM(P_URSM), .P_UCH(P_UCH), .P_CHBIT(P_CHBIT), .P_CHEND(P_CHEND))
	i_props (.*);

`default_nettype wire

/* File: sim/uhpet_timing_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module uhpet_timing_tb;
	import uhpet_pkg::*;
	localparam int DR = 2000, DM = 200, UR = 100, WK = 100, RQ = 200;
	localparam int DA = 400, CB = 50, CE = 100, UC = 100;
	logic clk, rst_n, us_se0_pin, us_k_pin, ds_se0_pin, ds_k_pin;
	logic port_suspended, bus_active, pkt_expect_resp, req_has_data;
	logic next_is_last, rep_se0_req, disc, rsm;
	logic port_reset_req, resume_req, wake_req, hs_enter, us_chirp_req;
	logic pkt_end, resp_start, req_start, data_sent, req_done;
	logic ds_reset_drv, ds_chirp_k_drv, ds_chirp_j_drv, ds_resume_drv;
	logic us_resume_drv, us_chirp_k_drv, ds_disconnect, us_long_k;
	logic us_reset_det, fs_revert, hs_mode, rep_se0_en, gap_same_ok;
	logic gap_opp_ok, resp_late, req_active, req_timeout, wake_refused;
	logic [9:0]  p;
	logic [11:0] klen;
	logic [17:0] o;
	int rise[18], hi[18], last[18];
	int mismatches = 0, cmp_count = 0;

	assign {req_done, data_sent, req_start, resp_start, pkt_end, us_chirp_req,
		hs_enter, wake_req, resume_req, port_reset_req} = p;
	assign o = {wake_refused, req_timeout, req_active, resp_late, gap_opp_ok,
		gap_same_ok, rep_se0_en, hs_mode, fs_revert, us_reset_det, us_long_k,
		ds_disconnect, us_chirp_k_drv, us_resume_drv, ds_resume_drv,
		ds_chirp_j_drv, ds_chirp_k_drv, ds_reset_drv};

	uhpet_timing #(.P_DRST(DR), .P_DRSM(DM), .P_URSM(UR), .P_WAKE(WK),
		.P_REV(100), .P_UCH(UC), .P_REQ(RQ), .P_DATA(DA), .P_CHBIT(CB),
		.P_CHEND(CE)) i_dut (.*);
	uhpet_far_end i_dev (.clk(clk), .ds_reset_drv(ds_reset_drv), .klen(klen),
		.disc(disc), .rsm(rsm), .ds_k_pin(ds_k_pin), .ds_se0_pin(ds_se0_pin));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %0d seen %0d", nm, e, s);
		end
	endtask

	// Watches every output for n cycles; pulses drop after the first edge.
	task run(input int n);
		for (int b = 0; b < 18; b++) begin
			hi[b] = 0;
			rise[b] = 0;
			last[b] = 0;
		end
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#1;
			if (i == 0) p = '0;
			for (int b = 0; b < 18; b++) begin
				if (o[b] === 1'b1) begin
					if (hi[b] == 0) rise[b] = i;
					hi[b]++;
					last[b] = i;
				end
			end
		end
	endtask

	task summarize;
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_chirp;
		int d, e;
		klen = 12'h3e8;
		p[0] = 1'b1;
		run(2400);
		d = rise[1] - rise[0];
		e = rise[0] + DR - 1 - (last[1] > last[2] ? last[1] : last[2]);
		chk("reset length", hi[0], DR);
		chk("first chirp delay", d > 1020 && d < 26100, 1);
		chk("chirp k bits", hi[1] > 0 && hi[1] % CB == 0, 1);
		chk("chirp j bits", hi[2] > 0 && hi[2] % CB == 0, 1);
		chk("sequence end gap", e >= CE - 1 && e <= CE + CB + 2, 1);
		$display("t_chirp done");
	endtask

	task t_nochirp;
		klen = 12'h12c;
		p[0] = 1'b1;
		run(2400);
		chk("short chirp refused", hi[1] + hi[2], 0);
		chk("reset length", hi[0], DR);
		$display("t_nochirp done");
	endtask

	task t_resume;
		p[1] = 1'b1;
		run(DM + 20);
		chk("ds resume length", hi[3], DM);
		port_suspended = 1'b1;
		rsm = 1'b1;
		run(UR + 20);
		chk("rebroadcast start", rise[4] <= 10 && hi[4] > 0, 1);
		chk("us resume length", hi[4], UR);
		rsm = 1'b0;
		port_suspended = 1'b0;
		$display("t_resume done");
	endtask

	task t_wake;
		bus_active = 1'b1;
		p[2] = 1'b1;
		run(5);
		chk("busy wake refused", hi[17] == 1 && hi[4] == 0, 1);
		bus_active = 1'b0;
		run(WK + 5);
		p[2] = 1'b1;
		run(UR + 20);
		chk("idle wake taken", hi[4] == UR && hi[17] == 0, 1);
		p[4] = 1'b1;
		run(UC + 10);
		chk("us chirp length", hi[5], UC);
		$display("t_wake done");
	endtask

	task t_gaps;
		pkt_expect_resp = 1'b1;
		p[5] = 1'b1;
		run(200);
		chk("fs gap", 200 - hi[12] >= 41 && 200 - hi[12] <= 44, 1);
		chk("fs gap opp", 200 - hi[13] >= 41 && 200 - hi[13] <= 44, 1);
		chk("fs late", hi[14] == 1 && rise[14] >= 134 && rise[14] <= 137, 1);
		p[3] = 1'b1;
		run(3);
		p[5] = 1'b1;
		run(120);
		chk("hs mode", hi[10], 120);
		chk("hs gap same", 120 - hi[12] >= 45 && 120 - hi[12] <= 48, 1);
		chk("hs gap opp", 120 - hi[13] >= 4 && 120 - hi[13] <= 7, 1);
		chk("hs late", hi[14] == 1 && rise[14] >= 99 && rise[14] <= 102, 1);
		pkt_expect_resp = 1'b0;
		$display("t_gaps done");
	endtask

	task t_lines;
		us_se0_pin = 1'b1;
		run(800);
		chk("revert", hi[9] == 1 && rise[9] >= 100 && rise[9] <= 106, 1);
		chk("full speed", o[10], 1'b0);
		chk("fs reset seen", hi[8], 1);
		us_se0_pin = 1'b0;
		us_k_pin = 1'b1;
		run(700);
		chk("long k", rise[7] >= 625 && rise[7] <= 635, 1);
		us_k_pin = 1'b0;
		disc = 1'b1;
		run(600);
		chk("disconnect", hi[6] == 1 && rise[6] >= 500 && rise[6] <= 506, 1);
		disc = 1'b0;
		rep_se0_req = 1'b1;
		run(600);
		chk("se0 repeat cut", hi[11] <= C_REP && hi[11] >= C_REP - 2, 1);
		rep_se0_req = 1'b0;
		$display("t_lines done");
	endtask

	task t_req;
		req_has_data = 1'b0;
		p[7] = 1'b1;
		run(RQ + 20);
		chk("no data budget", hi[16] == 1 && hi[15] >= RQ - 1 && hi[15] <= RQ + 1, 1);
		req_has_data = 1'b1;
		p[7] = 1'b1;
		run(DA - 50);
		chk("data budget", hi[16], 0);
		p[8] = 1'b1;
		run(DA - 50);
		chk("data reload", hi[16], 0);
		next_is_last = 1'b1;
		p[8] = 1'b1;
		run(RQ + 20);
		chk("last data", hi[16] == 1 && rise[16] >= RQ - 2 && rise[16] <= RQ + 2, 1);
		p[7] = 1'b1;
		run(10);
		p[9] = 1'b1;
		run(DA + 20);
		chk("done clears", hi[16] == 0 && o[15] === 1'b0, 1);
		$display("t_req done");
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#200000;
		mismatches++;
		summarize;
	end

	initial begin
		{rst_n, us_se0_pin, us_k_pin, port_suspended, bus_active} = '0;
		{pkt_expect_resp, req_has_data, next_is_last, rep_se0_req} = '0;
		{disc, rsm, p, klen} = '0;
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		run(2);
		t_chirp;
		t_nochirp;
		t_resume;
		t_wake;
		t_gaps;
		t_lines;
		t_req;
		summarize;
	end
endmodule

`default_nettype wire
